// *** clpsc_pkg.sv ***
// Package for the core low-power state controller: encodings and timing counts
package clpsc_pkg;

	// ****************************************
	// Core states and package states
	// ****************************************
	typedef enum logic [2:0] {
		CLPSC_C0,
		CLPSC_C1_HALT,
		CLPSC_C1_MONITOR_WAIT_INSTRUCTION,
		CLPSC_C2,
		CLPSC_C3,
		CLPSC_C4,
		CLPSC_SNOOP
	} clpsc_core_t;

	// Package state codes on o_pkg_state, ordered shallow to deep
	localparam logic [1:0] PKG_NORMAL     = 2'h0;
	localparam logic [1:0] PKG_STOP_GRANT = 2'h1;
	localparam logic [1:0] PKG_DEEP_SLEEP = 2'h2;
	localparam logic [1:0] PKG_DEEPER     = 2'h3;

	// Depth codes of a core request (hint or level read)
	localparam logic [1:0] REQ_C1 = 2'h0;
	localparam logic [1:0] REQ_C2 = 2'h1;
	localparam logic [1:0] REQ_C3 = 2'h2;
	localparam logic [1:0] REQ_C4 = 2'h3;

	// Level-read offsets within the power block (index 4,5,6 -> level 2,3,4 reads, depth from the hint fields)
	localparam logic [3:0] PBLK_LVL2 = 4'h4;
	localparam logic [3:0] PBLK_LVL3 = 4'h5;
	localparam logic [3:0] PBLK_LVL4 = 4'h6;

	// Field positions of the hint configuration in the misc enable word
	localparam int HINT_LVL2_LSB = 0;
	localparam int HINT_LVL3_LSB = 2;
	localparam int HINT_LVL4_LSB = 4;

	// Stop-grant entry bound after the acknowledge response phase
	localparam int STOP_GRANT_MAX_CLKS = 20;
	localparam int STOP_GRANT_DLY      = 4;

	// Number of cores in the package
	localparam int NUM_CORES = 2;

endpackage : clpsc_pkg

// *** clpsc_core_fsm.sv ***
// Per-core low-power state machine
`timescale 1ns/100ps
module clpsc_core_fsm
	import clpsc_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	// Requests
	input  wire logic              i_halt,
	input  wire logic              i_monitor_wait_instruction,
	input  wire logic [1:0]        i_monitor_wait_instruction_hint,
	input  wire logic              i_lvl_req,
	input  wire logic [1:0]        i_lvl_depth,
	// Events, already synchronised
	input  wire logic              i_wake,
	input  wire logic              i_monitor_event,
	input  wire logic              i_snoop,
	input  wire logic              i_snoop_done,
	input  wire logic              i_smi_resume_halt,
	// State
	output clpsc_pkg::clpsc_core_t o_state,
	output logic [1:0]             o_depth,
	output logic                   o_flush
);
	import clpsc_pkg::*;

	clpsc_core_t state;
	clpsc_core_t resume;
	clpsc_core_t next_state;
	clpsc_core_t next_resume;
	logic        idle_req;
	logic [1:0]  req_depth;
	clpsc_core_t req_state;
	logic        in_halt;
	logic        in_deep;

	// Level reads act like a monitor-wait with the configured hint, except that hint C1 enters C1 halt
	assign idle_req  = i_halt | i_monitor_wait_instruction | i_lvl_req;
	assign req_depth = i_lvl_req ? i_lvl_depth : i_monitor_wait_instruction_hint;
	assign in_halt   = (state == CLPSC_C1_HALT) | (state == CLPSC_C1_MONITOR_WAIT_INSTRUCTION);
	assign in_deep   = (state == CLPSC_C3) | (state == CLPSC_C4);

	// Level reads need no armed monitor, so the request alone is enough
	always_comb begin
		req_state = CLPSC_C1_MONITOR_WAIT_INSTRUCTION;
		if (i_halt) begin
			req_state = CLPSC_C1_HALT;
		end else begin
			unique case (req_depth)
				REQ_C1: req_state = i_lvl_req ? CLPSC_C1_HALT : CLPSC_C1_MONITOR_WAIT_INSTRUCTION;
				REQ_C2: req_state = CLPSC_C2;
				REQ_C3: req_state = CLPSC_C3;
				REQ_C4: req_state = CLPSC_C4;
			endcase
		end
	end

	// Transition logic
	always_comb begin
		next_state  = state;
		next_resume = resume;
		unique case (state)
			CLPSC_C0: begin
				if (idle_req) begin
					next_state = req_state;
				end else if (i_smi_resume_halt) begin
					next_state = CLPSC_C1_HALT;
				end
			end
			CLPSC_C1_HALT, CLPSC_C1_MONITOR_WAIT_INSTRUCTION, CLPSC_C2: begin
				if (i_wake || (state == CLPSC_C1_MONITOR_WAIT_INSTRUCTION && i_monitor_event)) begin
					next_state = CLPSC_C0;
				end else if (i_snoop) begin
					next_resume = state;
					next_state  = CLPSC_SNOOP;
				end
			end
			CLPSC_C3, CLPSC_C4: begin
				// Snoops are ignored here: caches are already flushed
				if (i_wake || i_monitor_event) begin
					next_state = CLPSC_C0;
				end
			end
			CLPSC_SNOOP: begin
				if (i_snoop_done) begin
					next_state = resume;
				end
			end
		endcase
	end

	// Reset initialises at once from any state
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state  <= CLPSC_C0;
			resume <= CLPSC_C0;
		end else begin
			state  <= next_state;
			resume <= next_resume;
		end
	end

	// Depth shown to the package combiner; snoop counts as its parked state
	always_comb begin
		o_depth = PKG_NORMAL;
		unique case ((state == CLPSC_SNOOP) ? resume : state)
			CLPSC_C2: o_depth = PKG_STOP_GRANT;
			CLPSC_C3: o_depth = PKG_DEEP_SLEEP;
			CLPSC_C4: o_depth = PKG_DEEPER;
			default:  o_depth = PKG_NORMAL;
		endcase
	end

	assign o_state = state;
	// One-cycle flush pulse on the way into a deep state
	assign o_flush = (state == CLPSC_C0) & idle_req & ((req_state == CLPSC_C3) |
		(req_state == CLPSC_C4));

	// ****************************************
	// Checks
	// ****************************************
	a_deep_snoop_stays: assert property (@(posedge i_clk) disable iff (i_rst)
		in_deep && i_snoop && !i_wake && !i_monitor_event |=> $stable(state))
		else $error("deep state left on snoop");
	a_halt_wake_c0: assert property (@(posedge i_clk) disable iff (i_rst)
		in_halt && i_wake |=> state == CLPSC_C0)
		else $error("halt not woken");
	a_snoop_returns: assert property (@(posedge i_clk) disable iff (i_rst)
		state == CLPSC_SNOOP && i_snoop_done |=> state == $past(resume))
		else $error("snoop did not return");
	a_deep_wake_c0: assert property (@(posedge i_clk) disable iff (i_rst)
		in_deep && (i_wake || i_monitor_event) |=> state == CLPSC_C0)
		else $error("deep state not woken");
	c_snoop_in_c2: cover property (@(posedge i_clk) state == CLPSC_C2 ##1 state == CLPSC_SNOOP);
	c_enter_c4: cover property (@(posedge i_clk) state == CLPSC_C0 ##1 state == CLPSC_C4);
endmodule // clpsc_core_fsm

// *** clpsc_ctrl.sv ***
// Top of the core and package low-power state controller
//
// Functional notes
// - Core C0/C1 map to Normal, C2 Stop Grant, C3 Deep Sleep, C4 Deeper Sleep.
// - Package entry is requested by a level-read I/O read to the chipset.
// - Level reads become monitor-wait requests; no bus I/O read is issued.
// - Level reads work without a monitor address being set up.
// - Hint per level read comes from a misc enable configuration field.
// - Break event while stop-clock asserted drives pending-break-event output.
// - Halt enters C1 halt; SMI, init, local irqs, bus irq return C0.
// - Reset initialises immediately from any core state.
// - SMI handler resumes in Normal or C1 halt.
// - Stop-clock in C1 halt returns to halt after its release.
// - C1 halt serves snoops in a snoop sub-state, then returns.
// - C1 monitor-wait is like halt and also wakes on monitor event.
// - C2 from level-2 read or hint; acknowledge cycle only with stop-clock.
// - C2 serves only snoops through a sub-state, then returns to C2.
// - C3 from level-3 read or hint; flush first-level cache before entry.
// - C3 stops core clocks, keeps state and armed monitor.
// - Snoop in C3 leaves the core in C3.
// - C3 wakes to C0 on monitor, SMI, init, local irq, bus irq.
// - C4 like C3; both cores in C4 request Deeper Sleep.
// - Stop-grant entered within 20 bus clocks after acknowledge response.
// - Stop-clock release returns core to its previous low-power state.
`timescale 1ns/100ps
module clpsc_ctrl
	import clpsc_pkg::*;
#(
	parameter int NCORE = clpsc_pkg::NUM_CORES
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// Per-core software requests (core clock domain)
	input  wire logic [NCORE-1:0] i_halt,
	input  wire logic [NCORE-1:0] i_monitor_wait_instruction,
	input  wire logic [2*NCORE-1:0] i_monitor_wait_instruction_hint,
	input  wire logic [NCORE-1:0] i_pblk_rd,
	input  wire logic [4*NCORE-1:0] i_pblk_addr,
	input  wire logic [NCORE-1:0] i_monitor_event,
	input  wire logic [NCORE-1:0] i_smi_resume_halt,
	// Misc enable hint configuration, three 2-bit fields
	input  wire logic [5:0]       i_misc_enable_msr,
	// Bus side events
	input  wire logic             i_snoop,
	input  wire logic             i_snoop_done,
	input  wire logic             i_bus_irq_msg,
	input  wire logic             i_ack_resp,
	// Pins from the chipset (asynchronous)
	input  wire logic             i_stop_clock_request_n,
	input  wire logic             i_system_mgmt_irq_n,
	input  wire logic             i_init_n,
	input  wire logic [1:0]       i_local_irq_pins,
	input  wire logic             i_break_event,
	// Outputs
	output logic                  o_pending_break_event_n,
	output logic                  o_stop_grant_ack,
	output logic                  o_stop_grant,
	output logic                  o_level_read_request,
	output logic [1:0]            o_pkg_state,
	output logic [NCORE-1:0]      o_core_clk_stop,
	output logic [NCORE-1:0]      o_l1_flush,
	output logic [3*NCORE-1:0]    o_core_state
);
	import clpsc_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;
	wire  [5:0] pin_raw = {i_break_event, i_local_irq_pins, ~i_init_n,
		~i_system_mgmt_irq_n, ~i_stop_clock_request_n};

	// Two flops; only the second stage is used by logic
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pin_meta <= 6'h00;
			pin_sync <= 6'h00;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	wire stop_clk  = pin_sync[0];
	wire brk_event = pin_sync[5];
	// Any interrupt source that ends a halt or deep state
	wire wake      = |pin_sync[4:1] | i_bus_irq_msg;

	// ****************************************
	// Cores
	// ****************************************
	logic [2*NCORE-1:0] depth;
	logic [3*NCORE-1:0] core_st;
	logic [NCORE-1:0]   flush;
	logic [NCORE-1:0]   clk_stop;

	genvar g;
	generate
		for (g = 0; g < NCORE; g++) begin : g_core
			wire [3:0]   addr = i_pblk_addr[4*g +: 4];
			wire         is_l2 = addr == PBLK_LVL2;
			wire         is_l3 = addr == PBLK_LVL3;
			wire         is_l4 = addr == PBLK_LVL4;
			wire         hit   = i_pblk_rd[g] & (is_l2 | is_l3 | is_l4);
			// Hint per level taken from the misc enable fields
			wire [1:0]   hint  = is_l2 ? i_misc_enable_msr[HINT_LVL2_LSB +: 2] :
				is_l3 ? i_misc_enable_msr[HINT_LVL3_LSB +: 2] :
				i_misc_enable_msr[HINT_LVL4_LSB +: 2];
			clpsc_core_t st;

			assign core_st[3*g +: 3] = 3'(st);

			clpsc_core_fsm u_core (
				.i_clk             (i_clk),
				.i_rst             (i_rst),
				.i_halt            (i_halt[g]),
				.i_monitor_wait_instruction           (i_monitor_wait_instruction[g]),
				.i_monitor_wait_instruction_hint      (i_monitor_wait_instruction_hint[2*g +: 2]),
				.i_lvl_req         (hit),
				.i_lvl_depth       (hint),
				.i_wake            (wake),
				.i_monitor_event   (i_monitor_event[g]),
				.i_snoop           (i_snoop),
				.i_snoop_done      (i_snoop_done),
				.i_smi_resume_halt (i_smi_resume_halt[g]),
				.o_state           (st),
				.o_depth           (depth[2*g +: 2]),
				.o_flush           (flush[g])
			);
			// Deep states stop the clocks of this core only
			assign clk_stop[g] = (st == CLPSC_C3) | (st == CLPSC_C4);
		end
	endgenerate

	// Core codes registered in one process so the whole output has one driver
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_core_state <= '0;
		end else begin
			o_core_state <= core_st;
		end
	end

	// ****************************************
	// Package state: shallowest core wins
	// ****************************************
	logic [1:0] pkg_min;
	always_comb begin
		pkg_min = PKG_DEEPER;
		for (int i = 0; i < NCORE; i++) begin
			if (depth[2*i +: 2] < pkg_min) begin
				pkg_min = depth[2*i +: 2];
			end
		end
	end

	// ****************************************
	// Stop-grant handshake
	// ****************************************
	// Acknowledge only when stop-clock is up and every core parked in C2 or deeper
	logic [4:0] sg_cnt;
	logic       sg_wait;
	logic       ack_sent;
	wire        want_ack = stop_clk & (pkg_min != PKG_NORMAL) & !ack_sent;
	wire        sg_hit   = sg_wait & (sg_cnt == 5'(STOP_GRANT_DLY));

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ack_sent <= 1'b0;
			sg_wait  <= 1'b0;
			sg_cnt   <= 5'h00;
		end else begin
			ack_sent <= stop_clk & (ack_sent | want_ack);
			sg_wait  <= stop_clk & ((sg_wait & !sg_hit) | i_ack_resp);
			sg_cnt   <= (sg_wait & stop_clk) ? sg_cnt + 5'h01 : 5'h00;
		end
	end

	// Registered outputs; stop-grant drops with stop-clock, the cores kept
	// their own states so they resume where they were
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_stop_grant_ack        <= 1'b0;
			o_stop_grant            <= 1'b0;
			o_pending_break_event_n <= 1'b1;
			o_level_read_request    <= 1'b0;
			o_pkg_state             <= PKG_NORMAL;
			o_core_clk_stop         <= '0;
			o_l1_flush              <= '0;
		end else begin
			o_stop_grant_ack        <= want_ack;
			o_stop_grant            <= stop_clk & (o_stop_grant | sg_hit);
			o_pending_break_event_n <= !(stop_clk & brk_event);
			// The chipset is asked by a level read each time the package goes deeper
			o_level_read_request    <= pkg_min > o_pkg_state;
			o_pkg_state             <= pkg_min;
			o_core_clk_stop         <= clk_stop;
			o_l1_flush              <= flush;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_pbe_follows_break: assert property (@(posedge i_clk) disable iff (i_rst)
		stop_clk && brk_event |=> !o_pending_break_event_n)
		else $error("pending break not asserted");
	a_pbe_needs_stop: assert property (@(posedge i_clk) disable iff (i_rst)
		!stop_clk |=> o_pending_break_event_n)
		else $error("pending break without stop-clock");
	a_ack_needs_stop: assert property (@(posedge i_clk) disable iff (i_rst)
		o_stop_grant_ack |-> $past(stop_clk))
		else $error("acknowledge without stop-clock");
	a_sg_within_bound: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ack_resp && stop_clk ##1 stop_clk[*7] |-> o_stop_grant)
		else $error("stop-grant late");
	a_sg_release: assert property (@(posedge i_clk) disable iff (i_rst)
		!stop_clk |=> !o_stop_grant)
		else $error("stop-grant held after release");
	a_pkg_map: assert property (@(posedge i_clk) disable iff (i_rst)
		1'b1 |=> o_pkg_state == $past(pkg_min))
		else $error("package state wrong");
	a_pkg_shallow: assert property (@(posedge i_clk) disable iff (i_rst)
		o_pkg_state == PKG_DEEPER |-> $past(depth) == {NCORE{PKG_DEEPER}})
		else $error("deeper sleep without all cores in C4");
	a_reset_normal: assert property (@(posedge i_clk)
		i_rst |=> o_pkg_state == PKG_NORMAL && o_pending_break_event_n)
		else $error("reset did not initialise");
	a_lvl_on_deeper: assert property (@(posedge i_clk) disable iff (i_rst)
		1'b1 |-> o_level_read_request == (o_pkg_state > $past(o_pkg_state)))
		else $error("level read request does not match package entry");
	c_deeper: cover property (@(posedge i_clk) o_pkg_state == PKG_DEEPER);
	c_stop_grant: cover property (@(posedge i_clk) o_stop_grant);
	c_break: cover property (@(posedge i_clk) !o_pending_break_event_n);
endmodule // clpsc_ctrl

// *** clpsc_chipset_model.sv ***
// Chipset-side model driving stop-clock and break-event pins of the controller
`timescale 1ns/100ps
module clpsc_chipset_model (
	// Clock and bench commands
	input  wire logic i_clk,
	input  wire logic i_stop_cmd,
	input  wire logic i_break_cmd,
	// Pins toward the controller
	input  wire logic i_pending_break_event_n,
	output logic      o_stop_clock_request_n = 1'b1,
	output logic      o_break_event          = 1'b0
);
	logic withdrawn = 1'b0;

	// A pending break during stop-clock withdraws the request until the next command
	always @(posedge i_clk) begin
		if (!i_stop_cmd)
			withdrawn <= 1'b0;
		else if (!i_pending_break_event_n)
			withdrawn <= 1'b1;
		o_stop_clock_request_n <= !i_stop_cmd || withdrawn || !i_pending_break_event_n;
		o_break_event <= i_break_cmd;
	end
endmodule // clpsc_chipset_model

// *** clpsc_ctrl_tb_top.sv ***
// Self-checking testbench of the low-power state controller
`timescale 1ns/100ps
module clpsc_ctrl_tb_top;
	import clpsc_pkg::*;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic       i_clk = 0, i_rst = 1, i_snoop = 0, i_snoop_done = 0, i_bus_irq_msg = 0;
	logic       i_ack_resp = 0, i_system_mgmt_irq_n = 1, i_init_n = 1, stop_cmd = 0, break_cmd = 0;
	logic [1:0] i_halt = 0, i_monitor_wait_instruction = 0, i_pblk_rd = 0, i_monitor_event = 0;
	logic [1:0] i_smi_resume_halt = 0, i_local_irq_pins = 0, last_pk = 0, cur_pk = 0;
	logic [3:0] i_monitor_wait_instruction_hint = 0, a;
	logic [7:0] i_pblk_addr = 0;
	logic [5:0] i_misc_enable_msr = 0, last_cs = 0, m;
	logic [2:0] f;
	logic [31:0] rng = 32'he063;
	wire logic  i_stop_clock_request_n, i_break_event, o_pending_break_event_n;
	wire logic  o_stop_grant_ack, o_stop_grant, o_level_read_request;
	wire logic [1:0] o_pkg_state, o_core_clk_stop, o_l1_flush;
	wire logic [5:0] o_core_state;
	int         err_count = 0, check_count = 0, exp_flush = 0, flush_cnt = 0, n;
	int         exp_lvl = 0, lvl_cnt = 0;
	logic [5:0] q_cs[$];
	logic [1:0] q_pk[$];

	always #25 i_clk = ~i_clk;

	clpsc_ctrl uut (.i_clk(i_clk), .i_rst(i_rst), .i_halt(i_halt), .i_monitor_wait_instruction(i_monitor_wait_instruction),
		.i_monitor_wait_instruction_hint(i_monitor_wait_instruction_hint), .i_pblk_rd(i_pblk_rd), .i_pblk_addr(i_pblk_addr),
		.i_monitor_event(i_monitor_event), .i_smi_resume_halt(i_smi_resume_halt),
		.i_misc_enable_msr(i_misc_enable_msr), .i_snoop(i_snoop), .i_snoop_done(i_snoop_done),
		.i_bus_irq_msg(i_bus_irq_msg), .i_ack_resp(i_ack_resp),
		.i_stop_clock_request_n(i_stop_clock_request_n),
		.i_system_mgmt_irq_n(i_system_mgmt_irq_n), .i_init_n(i_init_n),
		.i_local_irq_pins(i_local_irq_pins), .i_break_event(i_break_event),
		.o_pending_break_event_n(o_pending_break_event_n), .o_stop_grant_ack(o_stop_grant_ack),
		.o_stop_grant(o_stop_grant), .o_level_read_request(o_level_read_request),
		.o_pkg_state(o_pkg_state), .o_core_clk_stop(o_core_clk_stop),
		.o_l1_flush(o_l1_flush), .o_core_state(o_core_state));

	clpsc_chipset_model chipset (.i_clk(i_clk), .i_stop_cmd(stop_cmd), .i_break_cmd(break_cmd),
		.i_pending_break_event_n(o_pending_break_event_n),
		.o_stop_clock_request_n(i_stop_clock_request_n), .o_break_event(i_break_event));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	// Package depth of a core code; snoop is only used from C1 here
	function automatic logic [1:0] dp(logic [2:0] c);
		return (c == 3'h3) ? 2'h1 : (c == 3'h4) ? 2'h2 : (c == 3'h5) ? 2'h3 : 2'h0;
	endfunction

	task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, s);
		end
	endtask

	task automatic cyc(int k);
		repeat (k) @(posedge i_clk);
	endtask

	// Note the next core vector and, if it moves, the shallower-core package state
	task automatic ex(logic [2:0] c1, logic [2:0] c0);
		logic [1:0] p;
		p = (dp(c1) < dp(c0)) ? dp(c1) : dp(c0);
		if (p > cur_pk) exp_lvl++;
		q_cs.push_back({c1, c0});
		if (p != cur_pk) q_pk.push_back(p);
		cur_pk = p;
	endtask

	// Request kinds: 0 halt, 1 monitor-wait with hint, 2 level read at address
	task automatic req(int c, int kind, logic [3:0] v);
		@(posedge i_clk);
		case (kind)
			0: i_halt[c] <= 1'b1;
			1: begin
				i_monitor_wait_instruction[c] <= 1'b1;
				i_monitor_wait_instruction_hint[2*c+:2] <= v[1:0];
			end
			default: begin
				i_pblk_rd[c] <= 1'b1;
				i_pblk_addr[4*c+:4] <= v;
			end
		endcase
		@(posedge i_clk);
		i_halt <= 0;
		i_monitor_wait_instruction <= 0;
		i_pblk_rd <= 0;
		cyc(5);
	endtask

	// Single-cycle strobes: 0 snoop, 1 snoop done, 2 ack response, 3 bus irq, 4+c monitor
	task automatic bus(int k);
		@(posedge i_clk);
		case (k)
			0: i_snoop <= 1'b1;
			1: i_snoop_done <= 1'b1;
			2: i_ack_resp <= 1'b1;
			3: i_bus_irq_msg <= 1'b1;
			default: i_monitor_event[k-4] <= 1'b1;
		endcase
		@(posedge i_clk);
		{i_snoop, i_snoop_done, i_ack_resp, i_bus_irq_msg} <= 4'h0;
		i_monitor_event <= 0;
		cyc(5);
	endtask

	// Wake kinds: 0 management irq pin, 1 init pin, 2 local irq pin, 3 bus irq message
	task automatic wake(int k);
		logic [31:0] r;
		r = xs();
		if (k == 3) bus(3);
		else begin
			@(posedge i_clk);
			if (k == 0) i_system_mgmt_irq_n <= 1'b0;
			if (k == 1) i_init_n <= 1'b0;
			if (k == 2) i_local_irq_pins <= 2'h1 << r[0];
			cyc(4);
			{i_system_mgmt_irq_n, i_init_n, i_local_irq_pins} <= 4'hc;
			cyc(6);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ****************************************
	// Watcher: each output change takes the oldest note
	// ****************************************
	always @(posedge i_clk) begin
		if (!i_rst && o_core_state !== last_cs)
			chk("core_state", q_cs.size() ? q_cs.pop_front() : last_cs, o_core_state);
		if (!i_rst && o_pkg_state !== last_pk)
			chk("pkg_state", q_pk.size() ? q_pk.pop_front() : last_pk, o_pkg_state);
		if (o_level_read_request === 1'b1)
			lvl_cnt++;
		last_cs <= o_core_state;
		last_pk <= o_pkg_state;
		flush_cnt += $countones(o_l1_flush);
	end

	// Watchdog sized well past the expected run length
	initial begin
		#1000000;
		err_count++;
		conclude();
	end

	initial begin
		cyc(20);
		i_rst <= 1'b0;
		cyc(3);
		// Halt, snoop in halt, wake by management irq pin
		ex(0, 1); req(0, 0, 0);
		ex(0, 6); bus(0);
		ex(0, 1); bus(1);
		ex(0, 0); wake(0);
		ex(2, 0); req(1, 1, 4'h0);
		ex(0, 0); wake(2);
		$display("test halt done");
		// Handler resume to halt, then every monitor-wait hint on core 1
		@(posedge i_clk) i_smi_resume_halt[1] <= 1'b1;
		@(posedge i_clk) i_smi_resume_halt[1] <= 1'b0;
		ex(1, 0); cyc(5);
		ex(0, 0); bus(3);
		for (int h = 0; h < 4; h++) begin
			ex((h == 0) ? 3'h2 : 3'(h + 2), 0); req(1, 1, 4'(h));
			if (h >= 2) exp_flush++;
			ex(0, 0);
			if (h == 0) bus(5);
			else wake(int'(xs() % 4));
		end
		$display("test monitor wait done");
		// Level reads with random hint configuration; one unmapped offset
		repeat (8) begin
			a = 4'(4 + xs() % 3);
			m = 6'(xs());
			@(posedge i_clk) i_misc_enable_msr <= m;
			f = {1'b0, m[2*(a-4)+:2]};
			ex(0, (f == 0) ? 3'h1 : f + 3'h2); req(0, 2, a);
			if (f >= 2) exp_flush++;
			ex(0, 0); wake(int'(xs() % 4));
		end
		req(0, 2, 4'h9);
		$display("test level read done");
		// Stop-clock with one core in C2 and the other in C4
		@(posedge i_clk) i_misc_enable_msr <= 6'h3f;
		ex(5, 0); req(1, 2, 4'h6);
		exp_flush++;
		ex(5, 3); req(0, 1, 4'h1);
		chk("ack without stop clock", 0, o_stop_grant_ack);
		stop_cmd <= 1'b1;
		for (n = 0; o_stop_grant_ack !== 1'b1 && n < 10; n++) @(posedge i_clk);
		chk("stop grant ack", 1, o_stop_grant_ack);
		bus(2);
		for (n = 6; o_stop_grant !== 1'b1 && n < 30; n++) @(posedge i_clk);
		chk("stop grant in bound", 1, o_stop_grant === 1'b1 && n <= 20);
		break_cmd <= 1'b1;
		for (n = 0; o_pending_break_event_n !== 1'b0 && n < 10; n++) @(posedge i_clk);
		chk("pending break", 0, o_pending_break_event_n);
		for (n = 0; o_stop_grant !== 1'b0 && n < 10; n++) @(posedge i_clk);
		chk("core state after release", {2'h0, 3'h5, 3'h3}, o_core_state);
		break_cmd <= 1'b0;
		stop_cmd <= 1'b0;
		ex(0, 0); wake(3);
		$display("test stop clock done");
		// Both cores in C4, snoop leaves them parked, then reset mid-run
		ex(0, 5); req(0, 1, 4'h3);
		ex(5, 5); req(1, 2, 4'h6);
		exp_flush += 2;
		bus(0);
		chk("clocks stopped", 3, o_core_clk_stop);
		bus(1);
		ex(5, 0); bus(4);
		@(posedge i_clk) i_rst <= 1'b1;
		cyc(3);
		i_rst <= 1'b0;
		cur_pk = 0;
		cyc(2);
		chk("core state after reset", 0, o_core_state);
		chk("pkg state after reset", 0, o_pkg_state);
		chk("flush pulses", 8'(exp_flush), 8'(flush_cnt));
		chk("level read requests", 8'(exp_lvl), 8'(lvl_cnt));
		chk("notes left", 0, 8'(q_cs.size() + q_pk.size()));
		$display("test deeper sleep done");
		conclude();
	end
endmodule // clpsc_ctrl_tb_top
